// [instruction_format_decoder_regs.vh]
`ifndef INSTRUCTION_FORMAT_DECODER_REGS_VH
`define INSTRUCTION_FORMAT_DECODER_REGS_VH

// Instruction word and field layout.
`define INSN_WIDTH 32
`define DATA_WIDTH 64
`define OPCODE_HI 31
`define OPCODE_LO 26
`define FIRST_SRC_HI 25
`define FIRST_SRC_LO 21
`define SECOND_SRC_HI 20
`define SECOND_SRC_LO 16
`define MEM_DISP_HI 15
`define MEM_DISP_LO 0
`define BR_DISP_HI 20
`define BR_DISP_LO 0
`define LIT_SEL_BIT 12
`define IMM8_HI 20
`define IMM8_LO 13
`define INT_FUNC_HI 11
`define INT_FUNC_LO 5
`define FP_FUNC_HI 15
`define FP_FUNC_LO 5
`define DEST_HI 4
`define DEST_LO 0
`define LIB_FUNC_HI 25
`define LIB_FUNC_LO 0

// Register number that reads as zero.
`define ZERO_REG 5'h1f

// Format class codes.
`define FMT_LIB 3'h0
`define FMT_MEM 3'h1
`define FMT_MEMFN 3'h2
`define FMT_JUMP 3'h3
`define FMT_BRANCH 3'h4
`define FMT_INTOP 3'h5
`define FMT_FPOP 3'h6
`define FMT_RSVD 3'h7

// Branch test condition codes.
`define COND_EQ 4'h0
`define COND_NE 4'h1
`define COND_LT 4'h2
`define COND_LE 4'h3
`define COND_GT 4'h4
`define COND_GE 4'h5
`define COND_LBC 4'h6
`define COND_LBS 4'h7
`define COND_LTU 4'h8
`define COND_LEU 4'h9
`define COND_GTU 4'ha
`define COND_GEU 4'hb

// Reset values.
`define RST_INSN 32'h0000_0000
`define RST_WORD 64'h0000_0000_0000_0000
`define RST_BIT 1'b0
`define RST_CLASS `FMT_RSVD
`define RST_OPCODE 6'h00
`define RST_FIELD 5'h00
`define RST_FUNC16 16'h0000
`define RST_FUNC7 7'h00
`define RST_FUNC11 11'h000
`define RST_FUNC26 26'h000_0000

`endif

// [branch_condition_test.v]
`timescale 1ns/1ps
`default_nettype none

module branch_condition_test
(
  // Tested value and relation.
  input wire [63:0] value,
  input wire [3:0] cond,
  // Outcome.
  output reg taken
);

`include "instruction_format_decoder_regs.vh"

  wire isZero;
  wire isNeg;
  assign isZero = (value == `RST_WORD);
  assign isNeg = value[63];

  // Unsigned relations to zero collapse to constants (LTU, GEU) or zero tests (LEU, GTU).
  always @*
  begin
    case (cond)
      `COND_EQ: taken = isZero;
      `COND_NE: taken = !isZero;
      `COND_LT: taken = isNeg;
      `COND_LE: taken = isNeg | isZero;
      `COND_GT: taken = !isNeg & !isZero;
      `COND_GE: taken = !isNeg;
      `COND_LBC: taken = !value[0];
      `COND_LBS: taken = value[0];
      `COND_LTU: taken = 1'b0;
      `COND_LEU: taken = isZero;
      `COND_GTU: taken = !isZero;
      `COND_GEU: taken = 1'b1;
      default: taken = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// [instruction_format_decoder.v]
`timescale 1ns/1ps
`default_nettype none

module instruction_format_decoder
#(
  // Three class bits per opcode, opcode 0 in the lowest bits. By default only
  // opcode 0 is a library call word and every other opcode decodes as reserved.
  parameter [191:0] FORMAT_TABLE = {{63{3'h7}}, 3'h0},
  // Opcode that scales its displacement by 65536.
  parameter [5:0] LOAD_ADDRESS_HIGH_OP = 6'h09
)
(
  // Clock and reset.
  input wire clock,
  input wire arst_n,
  // Fetch stage.
  input wire insnValid,
  input wire [31:0] insnWord,
  input wire [63:0] updatedPc,
  input wire [3:0] branchCond,
  // Register file read data for the raw fields.
  input wire [63:0] firstSourceData,
  input wire [63:0] secondSourceData,
  input wire [63:0] fpFirstSourceData,
  input wire [63:0] fpSecondSourceData,
  // Decoded fields.
  output reg decValid_q,
  output reg [2:0] formatClass_q,
  output reg [5:0] opcode_q,
  output reg [4:0] first_source_field_q,
  output reg [4:0] second_source_field_q,
  output reg [4:0] dest_field_q,
  output reg [15:0] memFunction_q,
  output reg [15:0] jumpHint_q,
  output reg [6:0] intFunction_q,
  output reg [10:0] fpFunction_q,
  output reg [25:0] libFunction_q,
  output reg useImm8_q,
  output reg isLoadAddressHigh_q,
  output reg isHalt_q,
  // Operand values and addresses.
  output reg [63:0] firstOperand_q,
  output reg [63:0] secondOperand_q,
  output reg [63:0] memAddress_q,
  output reg [63:0] branchTarget_q,
  output reg branchTaken_q
);

`include "instruction_format_decoder_regs.vh"

  // Reset release.
  reg rstSync1_q;
  reg rstSync2_q;
  wire rstN;
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rstN = rstSync2_q;

  function [2:0] classOf;
    input [5:0] op;
    begin
      classOf = FORMAT_TABLE[op * 3 +: 3];
    end
  endfunction

  // Substitutes zero for a register field naming register 31.
  function [63:0] zeroSub;
    input [4:0] field;
    input [63:0] data;
    begin
      zeroSub = (field == `ZERO_REG) ? `RST_WORD : data;
    end
  endfunction

  wire [5:0] opcode = insnWord[`OPCODE_HI:`OPCODE_LO];
  wire [4:0] first_source_field = insnWord[`FIRST_SRC_HI:`FIRST_SRC_LO];
  wire [4:0] second_source_field = insnWord[`SECOND_SRC_HI:`SECOND_SRC_LO];
  wire [4:0] dest_field = insnWord[`DEST_HI:`DEST_LO];
  wire [15:0] memDisp = insnWord[`MEM_DISP_HI:`MEM_DISP_LO];
  wire [20:0] brDisp = insnWord[`BR_DISP_HI:`BR_DISP_LO];
  wire [7:0] imm8_field = insnWord[`IMM8_HI:`IMM8_LO];
  wire litSel = insnWord[`LIT_SEL_BIT];
  wire [2:0] fmt = classOf(opcode);
  wire isLah = (opcode == LOAD_ADDRESS_HIGH_OP);
  // One-hot class decode, shared by the function, hint, load address high, address and branch taken outputs.
  wire [7:0] classHit = 8'h01 << fmt;

  // Operand zero substitution; fields of 31 are how unused fields arrive.
  // Slot order is integer first, integer second, floating first, floating second.
  wire [255:0] rawData;
  wire [19:0] rawField;
  wire [255:0] subData;
  assign rawData = {fpSecondSourceData, fpFirstSourceData, secondSourceData, firstSourceData};
  assign rawField = {second_source_field, first_source_field, second_source_field,
    first_source_field};
  genvar slot;
  generate
    for (slot = 0; slot < 4; slot = slot + 1)
    begin : g_zero_sub
      assign subData[slot*64 +: 64] = zeroSub(rawField[slot*5 +: 5], rawData[slot*64 +: 64]);
    end
  endgenerate
  wire [63:0] intA = subData[63:0];
  wire [63:0] intB = subData[127:64];
  wire [63:0] fpA = subData[191:128];
  wire [63:0] fpB = subData[255:192];

  // Address arithmetic keeps the low 64 bits so overflow simply wraps.
  wire [63:0] dispExt = {{48{memDisp[15]}}, memDisp};
  wire [63:0] dispHigh = {{32{memDisp[15]}}, memDisp, 16'h0000};
  wire [63:0] memAddr = intB + (isLah ? dispHigh : dispExt);
  wire [63:0] brOffset = {{41{brDisp[20]}}, brDisp, 2'b00};
  wire [63:0] brTarget = updatedPc + brOffset;

  wire testTaken;
  branch_condition_test condTest
  (
    .value(intA),
    .cond(branchCond),
    .taken(testTaken)
  );

  // Operand selection by format class.
  reg [63:0] opA;
  reg [63:0] opB;
  reg litUsed;
  always @*
  begin
    opA = intA;
    opB = intB;
    litUsed = 1'b0;
    case (fmt)
      `FMT_INTOP:
      begin
        if (litSel)
        begin
          opB = {56'h0000_0000_0000_00, imm8_field};
          litUsed = 1'b1;
        end
      end
      `FMT_FPOP:
      begin
        // Fields pass through unchanged, so equal fields select one register.
        opA = fpA;
        opB = fpB;
      end
      default:
      begin
        opA = intA;
        opB = intB;
      end
    endcase
  end

  // Next values. Every output register loads on every edge; a cycle without a
  // valid word reloads the held value, except decValid_q which loads 0, so no register needs an enable.
  reg decValid_d;
  reg [2:0] formatClass_d;
  reg [5:0] opcode_d;
  reg [4:0] first_source_field_d;
  reg [4:0] second_source_field_d;
  reg [4:0] dest_field_d;
  reg [15:0] memFunction_d;
  reg [15:0] jumpHint_d;
  reg [6:0] intFunction_d;
  reg [10:0] fpFunction_d;
  reg [25:0] libFunction_d;
  reg useImm8_d;
  reg isLoadAddressHigh_d;
  reg isHalt_d;
  reg [63:0] firstOperand_d;
  reg [63:0] secondOperand_d;
  reg [63:0] memAddress_d;
  reg [63:0] branchTarget_d;
  reg branchTaken_d;

  always @*
  begin
    decValid_d = insnValid;
    formatClass_d = formatClass_q;
    opcode_d = opcode_q;
    first_source_field_d = first_source_field_q;
    second_source_field_d = second_source_field_q;
    dest_field_d = dest_field_q;
    memFunction_d = memFunction_q;
    jumpHint_d = jumpHint_q;
    intFunction_d = intFunction_q;
    fpFunction_d = fpFunction_q;
    libFunction_d = libFunction_q;
    useImm8_d = useImm8_q;
    isLoadAddressHigh_d = isLoadAddressHigh_q;
    isHalt_d = isHalt_q;
    firstOperand_d = firstOperand_q;
    secondOperand_d = secondOperand_q;
    memAddress_d = memAddress_q;
    branchTarget_d = branchTarget_q;
    branchTaken_d = branchTaken_q;
    if (insnValid)
    begin
      formatClass_d = fmt;
      opcode_d = opcode;
      first_source_field_d = first_source_field;
      second_source_field_d = second_source_field;
      dest_field_d = dest_field;
      memFunction_d = classHit[`FMT_MEMFN] ? memDisp : 16'h0000;
      jumpHint_d = classHit[`FMT_JUMP] ? memDisp : 16'h0000;
      intFunction_d = insnWord[`INT_FUNC_HI:`INT_FUNC_LO];
      fpFunction_d = insnWord[`FP_FUNC_HI:`FP_FUNC_LO];
      libFunction_d = insnWord[`LIB_FUNC_HI:`LIB_FUNC_LO];
      useImm8_d = litUsed;
      isLoadAddressHigh_d = isLah && classHit[`FMT_MEM];
      isHalt_d = (insnWord == `RST_INSN);
      firstOperand_d = opA;
      secondOperand_d = opB;
      // Jump words use the register value alone as their target.
      memAddress_d = classHit[`FMT_JUMP] ? intB : memAddr;
      branchTarget_d = brTarget;
      branchTaken_d = classHit[`FMT_BRANCH] && testTaken;
    end
  end

  always @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      decValid_q <= `RST_BIT;
      formatClass_q <= `RST_CLASS;
      opcode_q <= `RST_OPCODE;
      first_source_field_q <= `RST_FIELD;
      second_source_field_q <= `RST_FIELD;
      dest_field_q <= `RST_FIELD;
      memFunction_q <= `RST_FUNC16;
      jumpHint_q <= `RST_FUNC16;
      intFunction_q <= `RST_FUNC7;
      fpFunction_q <= `RST_FUNC11;
      libFunction_q <= `RST_FUNC26;
      useImm8_q <= `RST_BIT;
      isLoadAddressHigh_q <= `RST_BIT;
      isHalt_q <= `RST_BIT;
      firstOperand_q <= `RST_WORD;
      secondOperand_q <= `RST_WORD;
      memAddress_q <= `RST_WORD;
      branchTarget_q <= `RST_WORD;
      branchTaken_q <= `RST_BIT;
    end
    else
    begin
      decValid_q <= decValid_d;
      formatClass_q <= formatClass_d;
      opcode_q <= opcode_d;
      first_source_field_q <= first_source_field_d;
      second_source_field_q <= second_source_field_d;
      dest_field_q <= dest_field_d;
      memFunction_q <= memFunction_d;
      jumpHint_q <= jumpHint_d;
      intFunction_q <= intFunction_d;
      fpFunction_q <= fpFunction_d;
      libFunction_q <= libFunction_d;
      useImm8_q <= useImm8_d;
      isLoadAddressHigh_q <= isLoadAddressHigh_d;
      isHalt_q <= isHalt_d;
      firstOperand_q <= firstOperand_d;
      secondOperand_q <= secondOperand_d;
      memAddress_q <= memAddress_d;
      branchTarget_q <= branchTarget_d;
      branchTaken_q <= branchTaken_d;
    end
  end

endmodule
`default_nettype wire

// [register_file_model.sv]
`timescale 1ns/1ps
`default_nettype none
module register_file_model
(
  // Word whose fields are read.
  input wire logic [31:0] insnWord,
  // Read data.
  output logic [63:0] firstSourceData,
  output logic [63:0] secondSourceData,
  output logic [63:0] fpFirstSourceData,
  output logic [63:0] fpSecondSourceData
);
  // Register 31 reads as nonzero here, so a missing zero substitution shows.
  assign firstSourceData = {4'h9, {12{insnWord[25:21]}}};
  assign secondSourceData = {4'h9, {12{insnWord[20:16]}}};
  assign fpFirstSourceData = {4'h6, {12{~insnWord[25:21]}}};
  assign fpSecondSourceData = {4'h6, {12{~insnWord[20:16]}}};
endmodule
`default_nettype wire

// [instruction_format_decoder_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "instruction_format_decoder_regs.vh"
module instruction_format_decoder_chk
(
  // Inputs.
  input wire logic clock,
  input wire logic arst_n,
  input wire logic insnValid,
  input wire logic [31:0] insnWord,
  input wire logic [63:0] updatedPc,
  // Outputs.
  input wire logic decValid_q,
  input wire logic [2:0] formatClass_q,
  input wire logic [5:0] opcode_q,
  input wire logic [4:0] first_source_field_q,
  input wire logic [4:0] second_source_field_q,
  input wire logic [6:0] intFunction_q,
  input wire logic [10:0] fpFunction_q,
  input wire logic useImm8_q,
  input wire logic [63:0] firstOperand_q,
  input wire logic [63:0] secondOperand_q,
  input wire logic [63:0] branchTarget_q
);
  logic [31:0] word_q;
  logic [63:0] pc_q;
  always_ff @(posedge clock)
  begin
    word_q <= insnWord;
    pc_q <= updatedPc;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_taken;
    insnValid ##1 decValid_q;
  endsequence
  a_valid_delay: assert property (insnValid |=> decValid_q) else $error("no answer");
  a_idle_hold: assert property (!insnValid |=> !decValid_q && $stable(opcode_q))
    else $error("idle changed");
  a_word_fields: assert property (s_taken |-> opcode_q == word_q[31:26] &&
    first_source_field_q == word_q[25:21] && second_source_field_q == word_q[20:16])
    else $error("field wrong");
  a_func_fields: assert property (s_taken |-> intFunction_q == word_q[11:5] &&
    fpFunction_q == word_q[15:5]) else $error("function wrong");
  a_branch_target: assert property (s_taken |-> branchTarget_q ==
    pc_q + {{41{word_q[20]}}, word_q[20:0], 2'b00}) else $error("target wrong");
  a_imm8_zext: assert property (decValid_q && useImm8_q |->
    secondOperand_q == {56'h0, word_q[20:13]}) else $error("literal wrong");
  a_first_zero: assert property (decValid_q && first_source_field_q == 5'h1f |->
    firstOperand_q == 64'h0) else $error("first not zero");
  a_fp_zero: assert property (decValid_q && formatClass_q == `FMT_FPOP &&
    second_source_field_q == 5'h1f |-> secondOperand_q == 64'h0) else $error("second not zero");
endmodule
bind instruction_format_decoder instruction_format_decoder_chk chk (.clock, .arst_n, .insnValid,
  .insnWord, .updatedPc, .decValid_q, .formatClass_q, .opcode_q, .first_source_field_q,
  .second_source_field_q, .intFunction_q, .fpFunction_q, .useImm8_q, .firstOperand_q,
  .secondOperand_q, .branchTarget_q);
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Opcodes 0 to 6 take the classes in code order, opcode 9 is a memory word.
  localparam [191:0] FMT_MAP = {{54{3'h7}}, 3'h1, 3'h7, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1,
    3'h0};
  localparam [31:0] TAKEN = 32'h0c8e_0a69;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic insnValid = 1'b0;
  logic [31:0] insnWord = 32'h0000_0000;
  logic [63:0] updatedPc = 64'h0;
  logic [3:0] branchCond = 4'h0;
  logic [63:0] firstSourceData, secondSourceData, fpFirstSourceData, fpSecondSourceData;
  logic decValid_q, useImm8_q, isLoadAddressHigh_q, isHalt_q, branchTaken_q;
  logic [2:0] formatClass_q;
  logic [5:0] opcode_q;
  logic [4:0] first_source_field_q, second_source_field_q, dest_field_q;
  logic [15:0] memFunction_q, jumpHint_q;
  logic [6:0] intFunction_q;
  logic [10:0] fpFunction_q;
  logic [25:0] libFunction_q;
  logic [63:0] firstOperand_q, secondOperand_q, memAddress_q, branchTarget_q;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  register_file_model model (.insnWord, .firstSourceData, .secondSourceData, .fpFirstSourceData,
    .fpSecondSourceData);
  instruction_format_decoder #(.FORMAT_TABLE(FMT_MAP)) uut (.clock, .arst_n, .insnValid,
    .insnWord, .updatedPc, .branchCond, .firstSourceData, .secondSourceData, .fpFirstSourceData,
    .fpSecondSourceData, .decValid_q, .formatClass_q, .opcode_q, .first_source_field_q,
    .second_source_field_q, .dest_field_q, .memFunction_q, .jumpHint_q, .intFunction_q,
    .fpFunction_q, .libFunction_q, .useImm8_q, .isLoadAddressHigh_q, .isHalt_q,
    .firstOperand_q, .secondOperand_q, .memAddress_q, .branchTarget_q, .branchTaken_q);
  function automatic logic [63:0] iv(input logic [4:0] f);
    return {4'h9, {12{f}}};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [31:0] w);
    @(posedge clock);
    #1;
    insnWord = w;
    insnValid = 1'b1;
    @(posedge clock);
    #1;
    insnValid = 1'b0;
  endtask
  task automatic t_classes();
    for (int op = 0; op < 10; op++)
    begin
      send({op[5:0], 26'h3ff_ffff});
      check(formatClass_q, FMT_MAP[op*3 +: 3]);
      check(opcode_q, op[5:0]);
    end
  endtask
  task automatic t_memory();
    send({6'h01, 5'h03, 5'h07, 16'h8000});
    check(memAddress_q, iv(5'h07) + 64'hffff_ffff_ffff_8000);
    send({6'h09, 5'h03, 5'h07, 16'h8001});
    check(memAddress_q, iv(5'h07) + 64'hffff_ffff_8001_0000);
    check(isLoadAddressHigh_q, 1'b1);
    send({6'h02, 5'h1f, 5'h1f, 16'hbeef});
    check(memFunction_q, 16'hbeef);
    send({6'h03, 5'h1f, 5'h02, 16'h1234});
    check(jumpHint_q, 16'h1234);
    check(memAddress_q, iv(5'h02));
  endtask
  task automatic t_branch();
    updatedPc = 64'h1000;
    send({6'h04, 5'h05, 21'h1f_fffe});
    check(branchTarget_q, 64'h0ff8);
    check(first_source_field_q, 5'h05);
    for (int c = 0; c < 32; c++)
    begin
      branchCond = c[3:0];
      send({6'h04, c[4] ? 5'h01 : 5'h1f, 21'h00_0000});
      check(branchTaken_q, TAKEN[c]);
    end
  endtask
  task automatic t_intop();
    branchCond = 4'h0;
    send({6'h05, 5'h1f, 8'hff, 1'b1, 7'h55, 5'h0a});
    check(secondOperand_q, 64'h00ff);
    check(firstOperand_q, 64'h0);
    check(branchTaken_q, 1'b0);
    send({6'h05, 5'h04, 5'h06, 3'h0, 1'b0, 7'h2a, 5'h0b});
    check(secondOperand_q, iv(5'h06));
    check(dest_field_q, 5'h0b);
  endtask
  task automatic t_fpop();
    send({6'h06, 5'h04, 5'h1f, 11'h7ff, 5'h0c});
    check(firstOperand_q, {4'h6, {12{5'h1b}}});
    check(useImm8_q, 1'b0);
    send({6'h06, 5'h1f, 5'h08, 11'h01e, 5'h08});
    check(secondOperand_q, {4'h6, {12{5'h17}}});
    send(32'h0000_0000);
    check(isHalt_q, 1'b1);
    send(32'h0000_0001);
    check(isHalt_q, 1'b0);
    check(libFunction_q, 26'h000_0001);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (10) @(posedge clock);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge clock);
    t_classes();
    t_memory();
    t_branch();
    t_intop();
    t_fpop();
    complete_run();
  end
endmodule
`default_nettype wire
